// ==== verilog/dirc_pkg.sv ====
/*
 deep idle release control: register map, field positions, reset values,
 setup timer constants and state encoding.
 assumes a 32-bit Avalon-MM slave with byte addresses on word boundaries.
*/
package dirc_pkg;
   localparam int unsigned CLK_HZ = 100000000;
   localparam logic [3:0] ADDR_PSC = 4'h0;
   localparam logic [3:0] ADDR_PMS = 4'h4;
   localparam logic [3:0] ADDR_OSC_SETTLE_SELECT = 4'h8;
   localparam logic [3:0] ADDR_NFC = 4'hC;
   localparam int PSC_STP = 1;
   localparam int PSC_MASKABLE_IRQ_MASK = 4;
   localparam int PSC_NMI_SRC0_MASK = 5;
   localparam int PSC_NMI_SRC1_MASK = 6;
   localparam logic [1:0] PMS_DEEP_IDLE = 2'h2;
   localparam logic [2:0] OSC_SETTLE_SELECT_RESET = 3'h4;
   localparam logic [2:0] NFC_SLOW_LO = 3'h3;
   localparam logic [2:0] NFC_SLOW_HI = 3'h7;
   localparam int SETUP_BASE_LOG2 = 12;
   localparam int SETUP_W = 20;
   localparam logic [SETUP_W-1:0] SETUP_ONE = 20'h00001;
   localparam int NIRQ = 8;
   localparam int IRQ_EXT3 = 3;
   localparam logic [2:0] PRIO_NONE = 3'h7;
   typedef enum logic [3:0] {
      DIRC_RUN = 4'h1,
      DIRC_IDLE = 4'h2,
      DIRC_SETUP = 4'h4,
      DIRC_RESUME = 4'h8
   } dirc_state_t;
endpackage : dirc_pkg

// ==== verilog/dirc_top.sv ====
/*
 deep idle release control: entry, wake source qualification, setup timer,
 resume decision and per-peripheral clock gating during deep idle.
 assumes irq/nmi inputs are synchronous to mclk (the interrupt controller
 already filters them) and that the cpu halts on cpu_clk_en low.
*/
`timescale 1ns/1ps
module dirc_top (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic nmi0_req,
   input wire logic nmi1_req,
   input wire logic [7:0] irq_req,
   input wire logic [2:0] irq_req_prio,
   input wire logic [2:0] isr_prio,
   input wire logic in_isr,
   input wire logic irq_enabled_state,
   input wire logic subclock_used,
   input wire logic tmm_sel_r8,
   input wire logic tmm_sel_xt,
   input wire logic wt_sel_brg,
   input wire logic [1:0] csi_sel_ext,
   input wire logic uart0_sel_ext,
   input wire logic pll_on,
   output logic deep_idle,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic pll_en,
   output logic flash_clk_en,
   output logic intc_run,
   output logic wake_detect_en,
   output logic tmm_clk_en,
   output logic wt_clk_en,
   output logic wdt2_clk_en,
   output logic key_ret_en,
   output logic [1:0] csi_clk_en,
   output logic uart0_clk_en,
   output logic uart_other_clk_en,
   output logic adc_hold,
   output logic port_hold,
   output logic irq_ack,
   output logic nmi_ack,
   output logic resume_next
);
   typedef struct packed {
      dirc_pkg::dirc_state_t st;
      logic [6:0] power_save_ctrl;
      logic [1:0] pms;
      logic [2:0] osc_settle_select;
      logic [2:0] noise_filter_ctrl;
      logic [dirc_pkg::SETUP_W-1:0] cnt;
      logic wake_nmi;
      logic take_irq;
      logic pll_save;
      logic irq_ack;
      logic nmi_ack;
      logic resume_next;
      logic [31:0] rdata;
      logic rvalid;
   } dirc_s_t;

   dirc_s_t s_r;
   dirc_s_t s_nxt;
   logic nmi_ok;
   logic [7:0] irq_ok;
   logic irq_any;
   logic higher;
   logic [dirc_pkg::SETUP_W-1:0] setup_len;
   logic idle;
   logic acc;
   logic psc_wr;
   genvar gi;

   // masks and noise filter qualify sources
   always_comb
   begin
      nmi_ok = (nmi0_req & ~s_r.power_save_ctrl[dirc_pkg::PSC_NMI_SRC0_MASK])
             | (nmi1_req & ~s_r.power_save_ctrl[dirc_pkg::PSC_NMI_SRC1_MASK]);
      irq_ok = s_r.power_save_ctrl[dirc_pkg::PSC_MASKABLE_IRQ_MASK] ? 8'h00 : irq_req;
      if (s_r.noise_filter_ctrl >= dirc_pkg::NFC_SLOW_LO && s_r.noise_filter_ctrl <= dirc_pkg::NFC_SLOW_HI)
      begin
         irq_ok[dirc_pkg::IRQ_EXT3] = 1'b0;
      end
      irq_any = |irq_ok;
      higher = ~in_isr | (irq_req_prio < isr_prio);
      setup_len = dirc_pkg::SETUP_ONE << (dirc_pkg::SETUP_BASE_LOG2 + 32'(s_r.osc_settle_select));
   end

   assign acc = avs_read | avs_write;

   // accepted write to the control register this cycle
   always_comb
   begin
      psc_wr = 1'b0;
      if (avs_write && !s_r.rvalid && avs_byteenable[0])
      begin
         if (avs_address == dirc_pkg::ADDR_PSC)
         begin
            psc_wr = 1'b1;
         end
      end
   end

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.irq_ack = 1'b0;
      s_nxt.nmi_ack = 1'b0;
      s_nxt.resume_next = 1'b0;
      s_nxt.rvalid = 1'b0;
      if (avs_write && !s_r.rvalid)
      begin
         if (avs_address == dirc_pkg::ADDR_PSC)
         begin
            if (avs_byteenable[0])
            begin
               s_nxt.power_save_ctrl = avs_writedata[6:0];
            end
         end
         else if (avs_address == dirc_pkg::ADDR_PMS)
         begin
            if (avs_byteenable[0])
            begin
               s_nxt.pms = avs_writedata[1:0];
            end
         end
         else if (avs_address == dirc_pkg::ADDR_OSC_SETTLE_SELECT)
         begin
            if (avs_byteenable[0])
            begin
               s_nxt.osc_settle_select = avs_writedata[2:0];
            end
         end
         else if (avs_address == dirc_pkg::ADDR_NFC)
         begin
            if (avs_byteenable[0])
            begin
               s_nxt.noise_filter_ctrl = avs_writedata[2:0];
            end
         end
         s_nxt.rvalid = 1'b1;
      end
      else if (avs_read && !s_r.rvalid)
      begin
         s_nxt.rdata = 32'h00000000;
         if (avs_address == dirc_pkg::ADDR_PSC)
         begin
            s_nxt.rdata[6:0] = s_r.power_save_ctrl;
         end
         else if (avs_address == dirc_pkg::ADDR_PMS)
         begin
            s_nxt.rdata[1:0] = s_r.pms;
            s_nxt.rdata[11:8] = s_r.st;
         end
         else if (avs_address == dirc_pkg::ADDR_OSC_SETTLE_SELECT)
         begin
            s_nxt.rdata[2:0] = s_r.osc_settle_select;
         end
         else if (avs_address == dirc_pkg::ADDR_NFC)
         begin
            s_nxt.rdata[2:0] = s_r.noise_filter_ctrl;
         end
         s_nxt.rvalid = 1'b1;
      end
      case (s_r.st)
         dirc_pkg::DIRC_RUN:
         begin
            // trigger bit is self-clearing, so a stale 1 never re-enters
            if (s_r.power_save_ctrl[dirc_pkg::PSC_STP])
            begin
               // a new trigger written in the same cycle wins over the self-clear
               s_nxt.power_save_ctrl[dirc_pkg::PSC_STP] = psc_wr & avs_writedata[dirc_pkg::PSC_STP];
               if (s_r.pms == dirc_pkg::PMS_DEEP_IDLE)
               begin
                  s_nxt.st = dirc_pkg::DIRC_IDLE;
                  s_nxt.pll_save = pll_on;
               end
            end
         end
         dirc_pkg::DIRC_IDLE:
         begin
            // pending request at entry wakes on the first idle cycle
            if (nmi_ok || irq_any)
            begin
               s_nxt.st = dirc_pkg::DIRC_SETUP;
               s_nxt.cnt = setup_len;
               s_nxt.wake_nmi = nmi_ok;
               s_nxt.take_irq = nmi_ok | (irq_enabled_state & higher);
            end
         end
         dirc_pkg::DIRC_SETUP:
         begin
            s_nxt.cnt = s_r.cnt - dirc_pkg::SETUP_ONE;
            if (s_r.cnt == dirc_pkg::SETUP_ONE)
            begin
               s_nxt.st = dirc_pkg::DIRC_RESUME;
            end
         end
         dirc_pkg::DIRC_RESUME:
         begin
            s_nxt.st = dirc_pkg::DIRC_RUN;
            s_nxt.nmi_ack = s_r.wake_nmi;
            s_nxt.irq_ack = ~s_r.wake_nmi & s_r.take_irq;
            s_nxt.resume_next = ~s_r.take_irq;
         end
         default:
         begin
            s_nxt.st = dirc_pkg::DIRC_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         s_r <= '0;
         s_r.st <= dirc_pkg::DIRC_RUN;
         s_r.osc_settle_select <= dirc_pkg::OSC_SETTLE_SELECT_RESET;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign avs_waitrequest = acc & ~s_r.rvalid;
   assign avs_readdata = s_r.rdata;
   assign idle = (s_r.st == dirc_pkg::DIRC_IDLE) | (s_r.st == dirc_pkg::DIRC_SETUP);
   assign deep_idle = idle;

   // core clocks: cpu, peripherals and interrupt controller stop together
   always_comb
   begin
      cpu_clk_en = 1'b1;
      periph_clk_en = 1'b1;
      intc_run = 1'b1;
      flash_clk_en = 1'b1;
      pll_en = pll_on;
      if (s_r.st == dirc_pkg::DIRC_IDLE)
      begin
         cpu_clk_en = 1'b0;
         periph_clk_en = 1'b0;
         intc_run = 1'b0;
         flash_clk_en = 1'b0;
         pll_en = 1'b0;
      end
      else if (s_r.st == dirc_pkg::DIRC_SETUP)
      begin
         // flash and pll come back first so they settle before the fetch
         cpu_clk_en = 1'b0;
         periph_clk_en = 1'b0;
         intc_run = 1'b0;
         pll_en = s_r.pll_save;
      end
   end

   // wake detection never sleeps, or nothing could end the mode
   assign wake_detect_en = 1'b1;

   // gating only; the peripherals keep their own state while stopped
   always_comb
   begin
      tmm_clk_en = 1'b1;
      wt_clk_en = 1'b1;
      uart0_clk_en = 1'b1;
      uart_other_clk_en = 1'b1;
      adc_hold = 1'b0;
      port_hold = 1'b0;
      if (idle)
      begin
         tmm_clk_en = tmm_sel_r8 | (subclock_used & tmm_sel_xt);
         wt_clk_en = subclock_used | wt_sel_brg;
         uart0_clk_en = uart0_sel_ext;
         uart_other_clk_en = 1'b0;
         adc_hold = 1'b1;
         port_hold = 1'b1;
      end
   end

   assign wdt2_clk_en = 1'b1;
   assign key_ret_en = 1'b1;

   // one gate per clocked serial unit
   generate
      for (gi = 0; gi < $bits(csi_clk_en); gi++)
      begin : g_csi
         assign csi_clk_en[gi] = ~idle | csi_sel_ext[gi];
      end
   endgenerate
   assign irq_ack = s_r.irq_ack;
   assign nmi_ack = s_r.nmi_ack;
   assign resume_next = s_r.resume_next;
endmodule : dirc_top

// ==== tb/dirc_chk.sv ====
/* port assertions for dirc_top.
 assumes one mclk domain, bound by port name. */
`timescale 1ns/1ps
module dirc_chk (
   input logic mclk,
   input logic resetn,
   input logic deep_idle,
   input logic cpu_clk_en,
   input logic intc_run,
   input logic flash_clk_en,
   input logic pll_en,
   input logic pll_on,
   input logic port_hold,
   input logic adc_hold,
   input logic wdt2_clk_en,
   input logic key_ret_en,
   input logic irq_ack,
   input logic nmi_ack,
   input logic resume_next,
   input logic [1:0] csi_sel_ext,
   input logic [1:0] csi_clk_en,
   input logic uart0_sel_ext,
   input logic uart0_clk_en,
   input logic uart_other_clk_en,
   input logic periph_clk_en,
   input logic wake_detect_en,
   input logic tmm_clk_en,
   input logic tmm_sel_r8,
   input logic tmm_sel_xt,
   input logic subclock_used,
   input logic wt_clk_en,
   input logic wt_sel_brg
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   a_cpu_gated: assert property (deep_idle |-> !cpu_clk_en && !intc_run)
      else $error("cpu clock on in deep idle");
   a_flash_off: assert property (!flash_clk_en |-> deep_idle && !pll_en)
      else $error("flash or pll gating wrong");
   a_pins_held: assert property (deep_idle |-> port_hold && adc_hold)
      else $error("ports or adc not held");
   a_always_on: assert property (wdt2_clk_en && key_ret_en)
      else $error("watchdog or key return off");
   a_ack_after: assert property ((irq_ack || nmi_ack || resume_next) |->
      !deep_idle && ($past(deep_idle) || $past(deep_idle, 2))) else $error("pulse not at release");
   a_one_pulse: assert property ((irq_ack || nmi_ack || resume_next) |->
      $onehot({irq_ack, nmi_ack, resume_next}) ##1 !(irq_ack || nmi_ack || resume_next))
      else $error("release pulse not single");
   a_csi_gate: assert property (deep_idle && !flash_clk_en |-> csi_clk_en == csi_sel_ext)
      else $error("serial clock gating wrong");
   a_uart_gate: assert property (deep_idle && !flash_clk_en |->
      uart0_clk_en == uart0_sel_ext && !uart_other_clk_en) else $error("uart gating wrong");
   a_pll_back: assert property (!deep_idle |-> pll_en == pll_on)
      else $error("pll state not restored");
   a_tmm_gate: assert property (deep_idle |-> tmm_clk_en == (tmm_sel_r8 || (subclock_used && tmm_sel_xt)))
      else $error("interval timer gating wrong");
   a_wt_gate: assert property (deep_idle |-> wt_clk_en == (subclock_used || wt_sel_brg))
      else $error("watch timer gating wrong");
   a_periph_gate: assert property (deep_idle |-> !periph_clk_en && wake_detect_en)
      else $error("peripheral or wake detect gating wrong");
endmodule : dirc_chk
bind dirc_top dirc_chk dirc_chk_inst (.*);

// ==== tb/dirc_cpu_model.sv ====
/* cpu core and interrupt controller request model.
 assumes one-cycle raise pulses from the bench. */
`timescale 1ns/1ps
module dirc_cpu_model (
   input logic mclk,
   input logic resetn,
   input logic [7:0] raise_irq,
   input logic [1:0] raise_nmi,
   input logic irq_ack,
   input logic nmi_ack,
   output logic [7:0] irq_req,
   output logic nmi0_req,
   output logic nmi1_req
);
   // kept until acknowledged, so a plain resume leaves it pending
   always_ff @(posedge mclk)
      {irq_req, nmi1_req, nmi0_req} <= resetn ? {irq_req & ~{8{irq_ack}} | raise_irq,
         {nmi1_req, nmi0_req} & ~{2{nmi_ack}} | raise_nmi} : 10'h000;
endmodule : dirc_cpu_model

// ==== tb/deep_idle_release_control_tb.sv ====
/* bench for dirc_top: corner and random sleep and wake runs.
 assumes dirc_chk bound to the dut and dirc_cpu_model as source. */
`timescale 1ns/1ps
module deep_idle_release_control_tb;
   logic mclk, resetn, avs_read, avs_write, avs_waitrequest, nmi0_req, nmi1_req, in_isr;
   logic irq_enabled_state, subclock_used, tmm_sel_r8, tmm_sel_xt, wt_sel_brg, uart0_sel_ext;
   logic pll_on, deep_idle, irq_ack, nmi_ack, resume_next;
   logic [1:0] csi_sel_ext, raise_nmi;
   logic [2:0] irq_req_prio, isr_prio;
   logic [3:0] avs_address;
   logic [7:0] irq_req, raise_irq;
   logic [31:0] avs_writedata, avs_readdata, r, q;
   int n_errors, n_tests;
   dirc_top dirc_top_inst (.*, .avs_byteenable(4'hF), .cpu_clk_en(), .periph_clk_en(), .pll_en(),
      .flash_clk_en(), .intc_run(), .wake_detect_en(), .tmm_clk_en(), .wt_clk_en(),
      .wdt2_clk_en(), .key_ret_en(), .csi_clk_en(), .uart0_clk_en(), .uart_other_clk_en(),
      .adc_hold(), .port_hold());
   dirc_cpu_model dirc_cpu_model_inst (.*);
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [2:0] exp_pulse(input logic nm, ei, isr, input logic [2:0] rp, ip);
      return nm ? 3'h4 : (ei && (!isr || rp < ip)) ? 3'h2 : 3'h1;
   endfunction : exp_pulse
   task automatic give_verdict;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input string n, input logic [31:0] e, s);
      n_tests++;
      if (s !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // request stands until waitrequest is seen low at a rising edge
   task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      {avs_read, avs_write, avs_address, avs_writedata} <= {rd, !rd, a, d};
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      {avs_read, avs_write} <= 2'h0;
   endtask : bus
   task automatic run(input logic [1:0] nm, input logic [7:0] iq, input logic [6:0] power_save_ctrl,
      input logic [2:0] noise_filter_ctrl, input logic ok);
      int c;
      logic [2:0] p, e;
      r = lfsr(r);
      {subclock_used, tmm_sel_r8, tmm_sel_xt, wt_sel_brg, csi_sel_ext, uart0_sel_ext} <= r[6:0];
      {pll_on, in_isr, irq_enabled_state, irq_req_prio, isr_prio} <= r[15:7];
      bus(1'b0, dirc_pkg::ADDR_OSC_SETTLE_SELECT, 32'h0);
      bus(1'b0, dirc_pkg::ADDR_NFC, {29'h0, noise_filter_ctrl});
      bus(1'b0, dirc_pkg::ADDR_PMS, {30'h0, dirc_pkg::PMS_DEEP_IDLE});
      bus(1'b0, dirc_pkg::ADDR_PSC, {25'h0, power_save_ctrl} | 32'h2);
      repeat (2) @(negedge mclk);
      chk("deep_idle", 32'h1, deep_idle);
      @(posedge mclk) {raise_irq, raise_nmi} <= {iq, nm};
      @(posedge mclk) {raise_irq, raise_nmi} <= 10'h000;
      c = 1;
      p = 3'h0;
      do
      begin
         @(negedge mclk);
         c++;
         p |= {nmi_ack, irq_ack, resume_next};
      end
      while (deep_idle === 1'b1 && c < 5000);
      chk("idle_len", 32'h1, ok ? c >= 4096 && c <= 4100 : c == 5000);
      repeat (4)
      begin
         @(negedge mclk);
         p |= {nmi_ack, irq_ack, resume_next};
      end
      e = ok ? exp_pulse(nm != 2'h0, irq_enabled_state, in_isr, irq_req_prio, isr_prio) : 3'h0;
      chk("pulse", e, p);
      @(posedge mclk) resetn <= 1'b0;
      @(posedge mclk) resetn <= 1'b1;
      bus(1'b1, dirc_pkg::ADDR_OSC_SETTLE_SELECT, 32'h0);
      chk("osc_settle_select", {29'h0, dirc_pkg::OSC_SETTLE_SELECT_RESET}, q);
      @(negedge mclk);
      chk("deep_idle", 32'h0, deep_idle);
      bus(1'b1, 4'h1, 32'h0);
      chk("unmapped", 32'h0, q);
   endtask : run
   initial
   begin
      {resetn, avs_read, avs_write, avs_address, avs_writedata, raise_irq, raise_nmi} = '0;
      {subclock_used, tmm_sel_r8, tmm_sel_xt, wt_sel_brg, csi_sel_ext, uart0_sel_ext, pll_on} = '0;
      {in_isr, irq_enabled_state, irq_req_prio, isr_prio, n_errors, n_tests} = '0;
      r = 32'h2219;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      run(2'h1, 8'h00, 7'h20, 3'h0, 1'b0);
      run(2'h2, 8'h00, 7'h40, 3'h0, 1'b0);
      run(2'h0, 8'hFF, 7'h10, 3'h0, 1'b0);
      run(2'h0, 8'h08, 7'h00, dirc_pkg::NFC_SLOW_LO + r[2:0] % 3'h5, 1'b0);
      run(2'h0, 8'h08, 7'h00, 3'h2, 1'b1);
      repeat (8)
      begin
         r = lfsr(r);
         run(r[17:16] & {2{r[18]}}, r[27:20] | 8'h01, 7'h00, 3'h0, 1'b1);
      end
      give_verdict;
   end
   initial
   begin
      repeat (90000) @(posedge mclk);
      n_errors++;
      give_verdict;
   end
endmodule : deep_idle_release_control_tb
